/* File: rtl/exception_arbiter.sv */
`timescale 1ns/1ps
`default_nettype none
module exception_arbiter #(
    parameter int N = 48,
    parameter int KW = 4,
    parameter int IW = 6
) (
    input wire logic [N-1:0] cand_i,
    input wire logic [N-1:0][KW-1:0] key_i,
    output logic valid_o,
    output logic [IW-1:0] idx_o
);
    logic [KW-1:0] best_key;

    // Strict compare keeps the lowest number on a tie
    always_comb begin
        valid_o = 1'b0;
        idx_o = '0;
        best_key = '1;
        for (int i = 0; i < N; i++) begin
            if (cand_i[i] && (!valid_o || key_i[i] < best_key)) begin
                valid_o = 1'b1;
                idx_o = IW'(i);
                best_key = key_i[i];
            end
        end
    end
endmodule : exception_arbiter
`default_nettype wire

/* File: rtl/irq_source_select.sv */
`timescale 1ns/1ps
`default_nettype none
module irq_source_select (
    input wire vic_pkg::fixed_src_type fixed_i,
    input wire logic [15:0] dma_low_i,
    input wire logic [15:0] dma_high_i,
    input wire logic [31:0] array_i,
    input wire logic [31:0][1:0] sel_i,
    output logic [31:0] req_o
);
    import vic_pkg::*;
    logic [31:0] fixed_vec;
    logic [31:0] dma_vec;

    // Reserved fixed slots tie low
    assign fixed_vec[31:14] = {fixed_i.eeprom_fault, fixed_i.dma_hub_err, fixed_i.decimator, 3'h0,
        fixed_i.usb_ep_data, fixed_i.usb_ep0, fixed_i.usb_bus, fixed_i.usb_arb,
        fixed_i.usb_sof, fixed_i.timer, fixed_i.can, fixed_i.i2c, 1'b0};
    assign fixed_vec[13:0] = {fixed_i.comparators, fixed_i.port_unit_15, fixed_i.port_unit_12,
        fixed_i.port_interrupt_unit, fixed_i.sleep, 1'b0, fixed_i.cache_ecc,
        fixed_i.low_voltage_detect};
    assign dma_vec = {dma_high_i, dma_low_i};

    always_comb begin
        for (int n = 0; n < 32; n++) begin
            unique case (sel_i[n])
                SEL_FIXED: req_o[n] = fixed_vec[n];
                SEL_DMA: req_o[n] = dma_vec[n];
                SEL_ARRAY: req_o[n] = array_i[n];
                SEL_OFF: req_o[n] = 1'b0;
            endcase
        end
    end
endmodule : irq_source_select
`default_nettype wire

/* File: rtl/nested_vector_controller.sv */
`timescale 1ns/1ps
`default_nettype none
module nested_vector_controller #(
    parameter int PRIO_LEVELS = 8,
    parameter int STACK_DEPTH = 12,
    parameter int NUM_PINS = 64
) (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire vic_pkg::reg_req_type reg_i,
    output logic [31:0] rdata_o,
    input wire vic_pkg::fixed_src_type fixed_src_i,
    input wire logic [15:0] dma_term_bus_low_i,
    input wire logic [15:0] dma_term_bus_high_i,
    input wire logic [31:0] array_irq_i,
    input wire logic [NUM_PINS-1:0] pin_i,
    input wire vic_pkg::fault_req_type fault_i,
    input wire logic service_call_i,
    input wire logic debug_monitor_i,
    input wire logic system_tick_timer_i,
    input wire logic handler_exit_i,
    output vic_pkg::core_ctrl_type core_o
);
    import vic_pkg::*;
    localparam int DW = $clog2(STACK_DEPTH + 1);
    localparam logic [PRIO_W-1:0] PRIO_MAX = PRIO_W'(PRIO_LEVELS - 1);

    typedef struct packed {
        fsm_type fsm;
        logic [CNT_W-1:0] cnt;
        logic [NUM_EXC-1:0] pend;
        logic [5:0] chosen;
        logic [STACK_DEPTH-1:0][5:0] stk;
        logic [DW-1:0] depth;
        logic [31:0] enable;
        logic [31:0][1:0] src_sel;
        logic [31:0][PRIO_W-1:0] irq_prio;
        logic [NUM_SYS_PROG-1:0][PRIO_W-1:0] sys_prio;
        logic [1:0] split;
        logic [2:0] fault_en;
        logic nmi_en;
        logic [5:0] nmi_sel;
        logic [31:0] rdata;
    } state_type;

    state_type q;
    state_type d;
    logic [NUM_EXC-1:0][KEY_W-1:0] key;
    logic [NUM_EXC-1:0][KEY_W-1:0] grp;
    logic [NUM_EXC-1:0] cand;
    logic [NUM_EXC-1:0] active;
    logic [NUM_EXC-1:0] pend_set;
    logic [NUM_EXC-1:0] pend_clr;
    logic [31:0] irq_req;
    logic best_valid;
    logic [5:0] best_idx;
    logic [KEY_W-1:0] best_grp;
    logic [KEY_W-1:0] cur_grp;
    logic [KEY_W-1:0] pop_grp;
    logic preempt;
    logic tail_go;
    logic nmi_line;
    logic tie_bad;

    // Clamping on write keeps unimplemented levels out of arbitration
    function automatic logic [PRIO_W-1:0] clamp_prio(input logic [PRIO_W-1:0] p);
        clamp_prio = (p > PRIO_MAX) ? PRIO_MAX : p;
    endfunction : clamp_prio

    function automatic logic [KEY_W-1:0] prog_key(input logic [PRIO_W-1:0] p,
                                                  input logic [1:0] s);
        prog_key = KEY_PROG_BASE + KEY_W'(p >> s);
    endfunction : prog_key

    irq_source_select u_src (
        .fixed_i(fixed_src_i),
        .dma_low_i(dma_term_bus_low_i),
        .dma_high_i(dma_term_bus_high_i),
        .array_i(array_irq_i),
        .sel_i(q.src_sel),
        .req_o(irq_req)
    );

    exception_arbiter #(
        .N(NUM_EXC),
        .KW(KEY_W),
        .IW(6)
    ) u_arb (
        .cand_i(cand),
        .key_i(key),
        .valid_o(best_valid),
        .idx_o(best_idx)
    );

    always_comb begin
        for (int i = 0; i < NUM_EXC; i++) begin
            key[i] = KEY_THREAD;
            grp[i] = KEY_THREAD;
        end
        key[EXC_RESET] = KEY_RESET;
        grp[EXC_RESET] = KEY_RESET;
        key[EXC_NMI] = KEY_NMI;
        grp[EXC_NMI] = KEY_NMI;
        key[EXC_HARD] = KEY_HARD;
        grp[EXC_HARD] = KEY_HARD;
        for (int s = 0; s < NUM_SYS_PROG; s++) begin
            key[SYS_PROG_EXC[s]] = prog_key(q.sys_prio[s], 2'h0);
            grp[SYS_PROG_EXC[s]] = prog_key(q.sys_prio[s], q.split);
        end
        for (int n = 0; n < NUM_IRQ; n++) begin
            key[NUM_SYS + n] = prog_key(q.irq_prio[n], 2'h0);
            grp[NUM_SYS + n] = prog_key(q.irq_prio[n], q.split);
        end
        active = '0;
        for (int i = 0; i < STACK_DEPTH; i++) begin
            if (DW'(i) < q.depth) begin
                active[q.stk[i]] = 1'b1;
            end
        end
    end

    // Disabled interrupts stay pending but do not compete
    assign cand = q.pend & {q.enable, EXC_VALID_MASK};
    assign best_grp = grp[best_idx];
    assign cur_grp = (q.depth == '0) ? KEY_THREAD : grp[q.stk[0]];
    assign pop_grp = (q.depth > DW'(1)) ? grp[q.stk[1]] : KEY_THREAD;
    assign preempt = best_valid && (best_grp < cur_grp);
    assign tail_go = best_valid && (best_grp < pop_grp);
    assign nmi_line = q.nmi_en && (q.nmi_sel < NUM_PINS) && pin_i[q.nmi_sel];

    always_comb begin
        d = q;
        d.rdata = '0;
        pend_set = '0;
        pend_clr = '0;
        pend_set[EXC_NMI] = nmi_line;
        for (int f = 0; f < 3; f++) begin
            if (fault_i[f]) begin
                if (q.fault_en[f] && grp[EXC_MEM + f] < cur_grp) begin
                    pend_set[EXC_MEM + f] = 1'b1;
                end else begin
                    pend_set[EXC_HARD] = 1'b1;
                end
            end
        end
        pend_set[EXC_SVC] = service_call_i;
        pend_set[EXC_DBG] = debug_monitor_i;
        pend_set[EXC_TICK] = system_tick_timer_i;
        pend_set[NUM_EXC-1:NUM_SYS] = irq_req;

        if (reg_i.we) begin
            case (reg_i.addr)
                REG_ENABLE: d.enable = reg_i.wdata;
                REG_PEND_SET: pend_set[NUM_EXC-1:NUM_SYS] = irq_req | reg_i.wdata;
                REG_PEND_CLR: pend_clr[NUM_EXC-1:NUM_SYS] = reg_i.wdata;
                REG_SRC_LO: d.src_sel[15:0] = reg_i.wdata;
                REG_SRC_HI: d.src_sel[31:16] = reg_i.wdata;
                REG_SYS_PRIO: begin
                    for (int s = 0; s < NUM_SYS_PROG; s++) begin
                        d.sys_prio[s] = clamp_prio(reg_i.wdata[PRIO_FIELD_W*s +: PRIO_W]);
                    end
                end
                REG_SYS_CTRL: begin
                    d.split = reg_i.wdata[CTRL_SPLIT_LSB +: 2];
                    d.fault_en = reg_i.wdata[CTRL_FAULT_LSB +: 3];
                    d.nmi_en = reg_i.wdata[CTRL_NMI_EN_BIT];
                    d.nmi_sel = reg_i.wdata[CTRL_NMI_SEL_LSB +: 6];
                    pend_set[EXC_DEFER] = reg_i.wdata[CTRL_DEFER_BIT];
                end
                default: begin
                    if (reg_i.addr[7:4] == REG_PRIO_PAGE) begin
                        for (int i = 0; i < 8; i++) begin
                            d.irq_prio[{reg_i.addr[3:2], 3'(i)}] =
                                clamp_prio(reg_i.wdata[PRIO_FIELD_W*i +: PRIO_W]);
                        end
                    end
                end
            endcase
        end

        if (reg_i.re) begin
            case (reg_i.addr)
                REG_ENABLE: d.rdata = q.enable;
                REG_PEND_SET: d.rdata = q.pend[NUM_EXC-1:NUM_SYS];
                REG_PEND_CLR: d.rdata = q.pend[NUM_EXC-1:NUM_SYS];
                REG_ACTIVE: d.rdata = active[NUM_EXC-1:NUM_SYS];
                REG_SRC_LO: d.rdata = q.src_sel[15:0];
                REG_SRC_HI: d.rdata = q.src_sel[31:16];
                REG_SYS_PRIO: begin
                    for (int s = 0; s < NUM_SYS_PROG; s++) begin
                        d.rdata[PRIO_FIELD_W*s +: PRIO_W] = q.sys_prio[s];
                    end
                end
                REG_SYS_CTRL: begin
                    d.rdata[CTRL_SPLIT_LSB +: 2] = q.split;
                    d.rdata[CTRL_FAULT_LSB +: 3] = q.fault_en;
                    d.rdata[CTRL_NMI_EN_BIT] = q.nmi_en;
                    d.rdata[CTRL_NMI_SEL_LSB +: 6] = q.nmi_sel;
                    d.rdata[CTRL_DEFER_BIT] = q.pend[EXC_DEFER];
                end
                REG_STATUS: begin
                    d.rdata[5:0] = (q.depth == '0) ? EXC_NONE : q.stk[0];
                    d.rdata[STAT_BEST_LSB +: 6] = best_idx;
                    d.rdata[STAT_VALID_BIT] = best_valid;
                    d.rdata[STAT_DEPTH_LSB +: DW] = q.depth;
                end
                default: begin
                    if (reg_i.addr[7:4] == REG_PRIO_PAGE) begin
                        for (int i = 0; i < 8; i++) begin
                            d.rdata[PRIO_FIELD_W*i +: PRIO_W] =
                                q.irq_prio[{reg_i.addr[3:2], 3'(i)}];
                        end
                    end
                end
            endcase
        end

        unique case (q.fsm)
            ST_BOOT_SP: begin
                d.chosen = EXC_RESET;
                d.fsm = ST_BOOT_VEC;
            end
            ST_BOOT_VEC: d.fsm = ST_THREAD;
            ST_THREAD: begin
                if (preempt) begin
                    d.chosen = best_idx;
                    d.cnt = STACK_CNT_INIT;
                    d.fsm = ST_STACK;
                end
            end
            ST_HANDLER: begin
                if (handler_exit_i) begin
                    d.stk = q.stk >> 6;
                    d.depth = q.depth - DW'(1);
                    if (tail_go) begin
                        d.chosen = best_idx;
                        d.fsm = ST_ENTER;
                    end else begin
                        d.cnt = UNSTACK_CNT_INIT;
                        d.fsm = ST_UNSTACK;
                    end
                end else if (preempt) begin
                    d.chosen = best_idx;
                    d.cnt = STACK_CNT_INIT;
                    d.fsm = ST_STACK;
                end
            end
            ST_STACK: begin
                if (preempt) begin
                    d.chosen = best_idx;
                end
                if (q.cnt == '0) begin
                    d.fsm = ST_ENTER;
                end else begin
                    d.cnt = q.cnt - CNT_W'(1);
                end
            end
            ST_ENTER: begin
                pend_clr[q.chosen] = 1'b1;
                // Nesting beyond the stack depth is dropped; size it for all group levels
                if (q.depth < DW'(STACK_DEPTH)) begin
                    d.stk = {q.stk[STACK_DEPTH-2:0], q.chosen};
                    d.depth = q.depth + DW'(1);
                end
                d.fsm = ST_HANDLER;
            end
            ST_UNSTACK: begin
                if (q.cnt == '0) begin
                    d.fsm = (q.depth == '0) ? ST_THREAD : ST_HANDLER;
                end else begin
                    d.cnt = q.cnt - CNT_W'(1);
                end
            end
        endcase
        // A source that fires during the clear keeps its flag
        d.pend = (q.pend & ~pend_clr) | pend_set;
    end

    // Boot state encodes as zero, so the all-zero reset starts at the stack pointer fetch
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    always_comb begin
        core_o.stack = (q.fsm == ST_STACK);
        core_o.unstack = (q.fsm == ST_UNSTACK);
        core_o.fetch = (q.fsm == ST_BOOT_SP) || (q.fsm == ST_BOOT_VEC) || (q.fsm == ST_ENTER);
        core_o.exc_num = q.chosen;
        core_o.vec_offset = 10'({q.chosen, 2'h0});
    end
    assign rdata_o = q.rdata;

    always_comb begin
        tie_bad = 1'b0;
        for (int i = 0; i < NUM_EXC; i++) begin
            if (6'(i) < best_idx && cand[i] && key[i] <= key[best_idx]) begin
                tie_bad = 1'b1;
            end
        end
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!arst_n_i);

    AST_BOOT_ORDER: assert property (core_o.fetch && core_o.exc_num == EXC_RESET |->
        core_o.vec_offset == OFS_RESET &&
        $past(core_o.fetch && core_o.vec_offset == OFS_MSP))
        else $error("Boot fetch order wrong");
    AST_IRQ_OFFSET: assert property (core_o.fetch && core_o.exc_num >= EXC_IRQ_BASE |->
        core_o.vec_offset >= OFS_IRQ_FIRST && core_o.vec_offset <= OFS_IRQ_LAST)
        else $error("Interrupt vector offset out of range");
    AST_STACK_LEN: assert property ($rose(core_o.stack) |->
        core_o.stack [*8] ##1 core_o.fetch)
        else $error("Stacking length wrong");
    AST_UNSTACK_LEN: assert property ($rose(core_o.unstack) |->
        core_o.unstack [*8] ##1 !core_o.unstack)
        else $error("Unstacking length wrong");
    AST_TAIL_CHAIN: assert property (q.fsm == ST_HANDLER && handler_exit_i && tail_go |=>
        core_o.fetch && !core_o.unstack && !core_o.stack)
        else $error("Tail chain did not skip restore");
    AST_LATE_ARRIVAL: assert property (core_o.stack && preempt |=>
        core_o.exc_num == $past(best_idx))
        else $error("Late arrival not taken");
    AST_PREEMPT_GROUP: assert property ($rose(core_o.stack) |->
        $past(best_grp) < $past(cur_grp))
        else $error("Preemption without higher group");
    AST_NMI_TAKEN: assert property (q.fsm == ST_THREAD && q.pend[EXC_NMI] |=>
        core_o.stack)
        else $error("Pending NMI not taken");
    AST_ESCALATE: assert property (fault_i.mem_manage && !q.fault_en[0] |=>
        q.pend[EXC_HARD])
        else $error("Disabled fault not escalated");
    AST_PEND_CLEAR: assert property (q.fsm == ST_ENTER && !pend_set[q.chosen] |=>
        !q.pend[$past(q.chosen)])
        else $error("Pending not cleared at entry");
    AST_DMA_HIGH: assert property (q.src_sel[16] == SEL_DMA && dma_term_bus_high_i[0] |=>
        q.pend[EXC_IRQ_BASE + 16])
        else $error("High DMA bus not routed");
    AST_PRIO_LIMIT: assert property (reg_i.we && reg_i.addr == REG_SYS_PRIO |=>
        q.sys_prio[0] <= PRIO_MAX && q.sys_prio[6] <= PRIO_MAX)
        else $error("Priority beyond implemented levels");
    AST_LOWEST_WINS: assert property (best_valid |-> !tie_bad)
        else $error("Arbiter skipped a lower number");

    COV_TAIL: cover property (q.fsm == ST_HANDLER && handler_exit_i && tail_go);
    COV_LATE: cover property (core_o.stack && preempt && best_idx != q.chosen);
    COV_NEST: cover property (q.depth == DW'(2));
    COV_ESCALATE: cover property (fault_i.mem_manage && !q.fault_en[0]);
endmodule : nested_vector_controller
`default_nettype wire

/* File: rtl/vic_pkg.sv */
package vic_pkg;
    localparam int NUM_SYS = 16;
    localparam int NUM_IRQ = 32;
    localparam int NUM_EXC = 48;
    localparam int NUM_SYS_PROG = 7;
    localparam int PRIO_W = 3;
    localparam int PRIO_FIELD_W = 4;
    localparam int KEY_W = 4;
    localparam int CNT_W = 3;
    localparam int STACK_CYCLES = 8;
    localparam int UNSTACK_CYCLES = 8;
    localparam logic [CNT_W-1:0] STACK_CNT_INIT = CNT_W'(STACK_CYCLES - 1);
    localparam logic [CNT_W-1:0] UNSTACK_CNT_INIT = CNT_W'(UNSTACK_CYCLES - 1);
    localparam logic [5:0] EXC_NONE = 6'h00;
    localparam logic [5:0] EXC_RESET = 6'h01;
    localparam logic [5:0] EXC_NMI = 6'h02;
    localparam logic [5:0] EXC_HARD = 6'h03;
    localparam logic [5:0] EXC_MEM = 6'h04;
    localparam logic [5:0] EXC_BUS = 6'h05;
    localparam logic [5:0] EXC_USAGE = 6'h06;
    localparam logic [5:0] EXC_SVC = 6'h0B;
    localparam logic [5:0] EXC_DBG = 6'h0C;
    localparam logic [5:0] EXC_DEFER = 6'h0E;
    localparam logic [5:0] EXC_TICK = 6'h0F;
    localparam logic [5:0] EXC_IRQ_BASE = 6'h10;
    localparam logic [NUM_SYS_PROG-1:0][5:0] SYS_PROG_EXC =
        {EXC_TICK, EXC_DEFER, EXC_DBG, EXC_SVC, EXC_USAGE, EXC_BUS, EXC_MEM};
    localparam logic [15:0] EXC_VALID_MASK = 16'hD87E;
    localparam logic [9:0] OFS_MSP = 10'h000;
    localparam logic [9:0] OFS_RESET = 10'h004;
    localparam logic [9:0] OFS_IRQ_FIRST = 10'h040;
    localparam logic [9:0] OFS_IRQ_LAST = 10'h3FC;
    localparam logic [KEY_W-1:0] KEY_RESET = 4'h0;
    localparam logic [KEY_W-1:0] KEY_NMI = 4'h1;
    localparam logic [KEY_W-1:0] KEY_HARD = 4'h2;
    localparam logic [KEY_W-1:0] KEY_PROG_BASE = 4'h3;
    localparam logic [KEY_W-1:0] KEY_THREAD = 4'hF;
    localparam logic [1:0] SEL_FIXED = 2'h0;
    localparam logic [1:0] SEL_DMA = 2'h1;
    localparam logic [1:0] SEL_ARRAY = 2'h2;
    localparam logic [1:0] SEL_OFF = 2'h3;
    localparam logic [7:0] REG_ENABLE = 8'h00;
    localparam logic [7:0] REG_PEND_SET = 8'h04;
    localparam logic [7:0] REG_PEND_CLR = 8'h08;
    localparam logic [7:0] REG_ACTIVE = 8'h0C;
    localparam logic [7:0] REG_SRC_LO = 8'h10;
    localparam logic [7:0] REG_SRC_HI = 8'h14;
    localparam logic [3:0] REG_PRIO_PAGE = 4'h2;
    localparam logic [7:0] REG_SYS_PRIO = 8'h30;
    localparam logic [7:0] REG_SYS_CTRL = 8'h34;
    localparam logic [7:0] REG_STATUS = 8'h38;
    localparam int CTRL_SPLIT_LSB = 0;
    localparam int CTRL_FAULT_LSB = 4;
    localparam int CTRL_NMI_EN_BIT = 7;
    localparam int CTRL_NMI_SEL_LSB = 8;
    localparam int CTRL_DEFER_BIT = 16;
    localparam int STAT_BEST_LSB = 8;
    localparam int STAT_VALID_BIT = 16;
    localparam int STAT_DEPTH_LSB = 24;

    typedef enum logic [2:0] {
        ST_BOOT_SP, ST_BOOT_VEC, ST_THREAD, ST_STACK, ST_ENTER, ST_HANDLER, ST_UNSTACK
    } fsm_type;

    typedef struct packed {
        logic we;
        logic re;
        logic [7:0] addr;
        logic [31:0] wdata;
    } reg_req_type;

    typedef struct packed {
        logic eeprom_fault;
        logic dma_hub_err;
        logic decimator;
        logic usb_ep_data;
        logic usb_ep0;
        logic usb_bus;
        logic usb_arb;
        logic usb_sof;
        logic [3:0] timer;
        logic can;
        logic i2c;
        logic comparators;
        logic port_unit_15;
        logic port_unit_12;
        logic [6:0] port_interrupt_unit;
        logic sleep;
        logic cache_ecc;
        logic low_voltage_detect;
    } fixed_src_type;

    typedef struct packed {
        logic usage;
        logic bus;
        logic mem_manage;
    } fault_req_type;

    typedef struct packed {
        logic stack;
        logic unstack;
        logic fetch;
        logic [5:0] exc_num;
        logic [9:0] vec_offset;
    } core_ctrl_type;
endpackage : vic_pkg

/* File: sim/core_model.sv */
`timescale 1ns/1ps
`default_nettype none
module core_model (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire vic_pkg::core_ctrl_type core_i,
    output logic handler_exit_o
);
    import vic_pkg::*;
    int owed;
    int wait_c;
    logic [31:0] vec_word;
    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            owed <= 0;
            wait_c <= 0;
            vec_word <= 32'h0;
            handler_exit_o <= 1'b0;
        end else begin
            handler_exit_o <= 1'b0;
            if (core_i.fetch && core_i.exc_num > EXC_RESET) begin
                vec_word <= {22'h0, core_i.vec_offset} | 32'h1;
                owed <= owed + 1;
                wait_c <= $urandom_range(1, 9);
            end else if (wait_c > 0) begin
                wait_c <= wait_c - 1;
            end else if (owed > 0 && !core_i.stack && !core_i.unstack) begin
                // Pause after an exit so a second one never lands in restore
                handler_exit_o <= 1'b1;
                owed <= owed - 1;
                wait_c <= 3;
            end
        end
    end
endmodule : core_model
`default_nettype wire

/* File: sim/nested_vector_controller_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module nested_vector_controller_tb;
    import vic_pkg::*;
    logic clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    reg_req_type reg_i = '0;
    logic [31:0] rdata_o;
    fixed_src_type fixed_src_i = '0;
    logic [31:0] dma_bus = '0;
    logic [31:0] array_irq_i = '0;
    logic [63:0] pin_i = '0;
    fault_req_type fault_i = '0;
    logic [2:0] sys_req = '0;
    int stk_n = 0;
    int unstk_n = 0;
    logic handler_exit_i;
    core_ctrl_type core_o;
    int num_errors = 0;
    int checks = 0;
    int n;
    logic [15:0] exp_q[$];
    logic [31:0] rd_q[$];
    logic live = 1'b0;
    logic re_seen = 1'b0;
    // Five levels so that clamping of written priorities is exercised
    nested_vector_controller #(.PRIO_LEVELS(5)) uut (.clk_i(clk_i), .arst_n_i(arst_n_i),
        .reg_i(reg_i), .rdata_o(rdata_o), .fixed_src_i(fixed_src_i),
        .dma_term_bus_low_i(dma_bus[15:0]), .dma_term_bus_high_i(dma_bus[31:16]),
        .array_irq_i(array_irq_i), .pin_i(pin_i), .fault_i(fault_i),
        .service_call_i(sys_req[0]), .debug_monitor_i(sys_req[1]),
        .system_tick_timer_i(sys_req[2]), .handler_exit_i(handler_exit_i), .core_o(core_o));
    core_model core (.clk_i(clk_i), .arst_n_i(arst_n_i), .core_i(core_o),
        .handler_exit_o(handler_exit_i));
    initial begin
        forever #10 clk_i = ~clk_i;
    end
    task automatic complete_run;
        if (num_errors == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : complete_run
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp
    // Skip the cycle still holding reset values after release
    always @(posedge clk_i) begin
        live <= arst_n_i;
        re_seen <= reg_i.re;
        stk_n <= core_o.stack ? stk_n + 1 : 0;
        unstk_n <= core_o.unstack ? unstk_n + 1 : 0;
        if (!core_o.stack && stk_n != 0) cmp(32'(stk_n), 32'(STACK_CYCLES));
        if (!core_o.unstack && unstk_n != 0) cmp(32'(unstk_n), 32'(UNSTACK_CYCLES));
        if (live && core_o.fetch)
            cmp({16'h0, core_o.exc_num, core_o.vec_offset},
                exp_q.size() > 0 ? {16'h0, exp_q.pop_front()} : 32'hFFFF_FFFF);
        if (re_seen) cmp(rdata_o, rd_q.pop_front());
    end
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i) reg_i <= '{we: w, re: !w, addr: a, wdata: d};
        @(posedge clk_i) reg_i <= '0;
    endtask : bus
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        rd_q.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask : rd
    task automatic want(input logic [5:0] e);
        exp_q.push_back({e, 2'b00, e, 2'b00});
    endtask : want
    task automatic drain;
        for (int i = 0; i < 400 && exp_q.size() > 0; i++) @(posedge clk_i);
        // A vector that never came is a failure, not a silent leftover
        cmp(32'(exp_q.size()), 32'h0);
        exp_q.delete();
        repeat (30) @(posedge clk_i);
    endtask : drain
    initial begin
        void'($urandom(32'h6540));
        want(EXC_RESET);
        repeat (12) @(posedge clk_i);
        arst_n_i <= 1'b1;
        drain();
        for (int s = 0; s < 4; s++) begin
            n = (s == 0) ? 17 + $urandom_range(0, 3) : $urandom_range(0, 31);
            bus(1'b1, n < 16 ? REG_SRC_LO : REG_SRC_HI, 32'(s) << (2 * (n % 16)));
            bus(1'b1, REG_ENABLE, 32'h1 << n);
            if (s != 3) want(EXC_IRQ_BASE + 6'(n));
            @(posedge clk_i);
            fixed_src_i.timer <= (s == 0) ? 4'(1 << (n - 17)) : 4'h0;
            dma_bus <= (s == 1) ? 32'h1 << n : 32'h0;
            array_irq_i <= (s >= 2) ? 32'h1 << n : 32'h0;
            @(posedge clk_i);
            fixed_src_i <= '0;
            dma_bus <= '0;
            array_irq_i <= '0;
            drain();
        end
        n = $urandom_range(0, 30);
        bus(1'b1, REG_ENABLE, 32'h3 << n);
        want(EXC_IRQ_BASE + 6'(n));
        want(EXC_IRQ_BASE + 6'(n + 1));
        bus(1'b1, REG_PEND_SET, 32'h3 << n);
        drain();
        rd(REG_PEND_SET, 32'h0);
        rd(REG_ENABLE, 32'h3 << n);
        bus(1'b1, REG_ENABLE, 32'h44);
        bus(1'b1, 8'h20, 32'h0100_0200);
        rd(8'h20, 32'h0100_0200);
        want(EXC_IRQ_BASE + 6'd6);
        want(EXC_IRQ_BASE + 6'd2);
        bus(1'b1, REG_PEND_SET, 32'h44);
        drain();
        n = $urandom_range(0, 62);
        bus(1'b1, REG_SYS_CTRL, 32'h80 | (32'(n) << 8));
        want(EXC_NMI);
        @(posedge clk_i) pin_i <= 64'h1 << (n + 1);
        @(posedge clk_i) pin_i <= 64'h1 << n;
        @(posedge clk_i) pin_i <= '0;
        drain();
        bus(1'b1, REG_SYS_PRIO, 32'h0777_7777);
        rd(REG_SYS_PRIO, 32'h0444_4444);
        bus(1'b1, REG_SYS_CTRL, 32'h0);
        want(EXC_HARD);
        @(posedge clk_i) fault_i.mem_manage <= 1'b1;
        @(posedge clk_i) fault_i <= '0;
        drain();
        bus(1'b1, REG_SYS_CTRL, 32'h10);
        want(EXC_MEM);
        @(posedge clk_i) fault_i.mem_manage <= 1'b1;
        @(posedge clk_i) fault_i <= '0;
        drain();
        for (int k = 0; k < 3; k++) begin
            want(k == 0 ? EXC_SVC : (k == 1 ? EXC_DBG : EXC_TICK));
            @(posedge clk_i) sys_req <= 3'(1 << k);
            @(posedge clk_i) sys_req <= '0;
            drain();
        end
        want(EXC_DEFER);
        bus(1'b1, REG_SYS_CTRL, 32'h1_0000);
        drain();
        rd(8'hFC, 32'h0);
        repeat (3) @(posedge clk_i);
        complete_run();
    end
    initial begin
        #400us;
        num_errors++;
        complete_run();
    end
endmodule : nested_vector_controller_tb
`default_nettype wire
